//--- bench/lcd_host_command_port_bench.sv
`timescale 1ns/1ns
module lcd_host_command_port_bench;
   import lhcp_pkg::*;
   localparam logic [1:0] HL = 2'h1;
   localparam logic [1:0] HR = 2'h2;
   localparam logic [1:0] HB = 2'h3;
   logic        clk_sys;
   logic        reset_n;
   logic [3:0]  regAddr;
   logic [15:0] regWrData;
   logic        regWrite;
   logic        regRead;
   logic [15:0] regRdData;
   logic [15:0] rb;
   logic [1:0]  displayOn, segmentDirection, staticDrive, dutyIs32;
   logic [9:0]  startLine, scanLine;
   int          fails = 0;
   int          checked = 0;
   int          cycles = 0;

   lhcp_bus_if bus ();
   lhcp_host i_lhcp_host (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .bus(bus));
   lhcp_device i_lhcp_device (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus),
      .displayOn(displayOn), .segmentDirection(segmentDirection), .staticDrive(staticDrive),
      .dutyIs32(dutyIs32), .startLine(startLine), .scanLine(scanLine));
   lhcp_bus_chk i_lhcp_bus_chk (.clk_sys(clk_sys), .reset_n(reset_n),
      .dataCommandSelect(bus.dataCommandSelect), .readNotWrite(bus.readNotWrite),
      .leftHalfSelect(bus.leftHalfSelect), .rightHalfSelect(bus.rightHalfSelect),
      .hardwareResetN(bus.hardwareResetN), .hostBusOut(bus.hostBusOut),
      .hostBusOe(bus.hostBusOe), .devBusOut(bus.devBusOut), .devBusOe(bus.devBusOe),
      .busLevel(bus.busLevel));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic end_sim();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fails = fails + 1;
         end_sim();
      end
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // ----------------------------------------
   // register port and link access
   // ----------------------------------------
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 rb = regRdData;
   endtask

   task automatic poll();
      int n;
      n = 0;
      do begin
         rd(REG_STATUS);
         n++;
      end while (rb[0] !== 1'b0 && n < 200);
   endtask

   task automatic op(input logic [1:0] h, input logic rnw, input logic dcs,
                     input logic [7:0] d);
      wr(REG_ACCESS, {4'h0, h, rnw, dcs, d});
      poll();
      if (rnw) rd(REG_RDATA);
   endtask

   task automatic cmd(input logic [7:0] d);
      op(HL, 1'b0, 1'b0, d);
   endtask

   task automatic wd(input logic [7:0] d);
      op(HL, 1'b0, 1'b1, d);
   endtask

   task automatic rdd();
      op(HL, 1'b1, 1'b1, 8'h00);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_modes();
      logic [7:0] cs [4] = '{8'hAF, 8'hA1, 8'hA5, 8'hA9};
      op(HL, 1'b1, 1'b0, 8'h00);
      chk("status_rst", rb[7:0], 8'h20);
      for (int i = 0; i < 4; i++) cmd(cs[i]);
      chk("on", displayOn, 2'h1);
      chk("segdir", segmentDirection, 2'h1);
      chk("static", staticDrive, 2'h1);
      chk("duty", dutyIs32, 2'h1);
      op(HL, 1'b1, 1'b0, 8'h00);
      chk("status_set", rb[7:0], 8'h40);
      for (int i = 0; i < 4; i++) cmd(cs[i] & MASK_LOWBIT);
      chk("modes_off", {displayOn, segmentDirection, staticDrive, dutyIs32}, 8'h00);
   endtask

   task automatic t_lines();
      op(HR, 1'b0, 1'b0, 8'hC7);
      chk("line_r", startLine, 10'h0E0);
      cmd(8'hDF);
      chk("line_l", startLine, 10'h0FF);
      op(HB, 1'b0, 1'b0, 8'hB8);
      op(HB, 1'b0, 1'b0, 8'hE2);
      chk("line_clr", startLine, 10'h000);
      cmd(8'h10);
      wd(8'h3C);
      cmd(8'hBB);
      cmd(8'h10);
      rdd();
      rdd();
      chk("page3", rb[7:0], 8'h3C);
   endtask

   task automatic t_data();
      cmd(8'hB9);
      cmd(8'h05);
      wd(8'hAA);
      wd(8'h55);
      // right half keeps its own RAM at the same column
      op(HR, 1'b0, 1'b0, 8'h05);
      op(HR, 1'b0, 1'b1, 8'h5A);
      op(HR, 1'b0, 1'b0, 8'h05);
      op(HR, 1'b1, 1'b1, 8'h00);
      op(HR, 1'b1, 1'b1, 8'h00);
      chk("ram_right", rb[7:0], 8'h5A);
      cmd(8'h05);
      rdd();
      rdd();
      chk("ram0", rb[7:0], 8'hAA);
      rdd();
      chk("ram1", rb[7:0], 8'h55);
      cmd(8'h4F);
      wd(8'h11);
      wd(8'h22);
      cmd(8'h4F);
      rdd();
      rdd();
      chk("lastcol", rb[7:0], 8'h11);
      rdd();
      chk("stopcol", rb[7:0], 8'h00);
   endtask

   task automatic t_rmw();
      cmd(8'h03);
      wd(8'h33);
      cmd(8'h03);
      cmd(8'hE0);
      rdd();
      rdd();
      chk("rmw_rd", rb[7:0], 8'h33);
      wd(8'h44);
      cmd(8'hEE);
      rdd();
      rdd();
      chk("rmw_end", rb[7:0], 8'h44);
   endtask

   // rows shown start at the start line and span the duty
   task automatic t_scan();
      logic [4:0] off;
      logic [4:0] top;
      logic       hit;
      for (int d = 0; d < 2; d++) begin
         cmd(d ? 8'hA9 : 8'hDC);
         top = 5'h00;
         hit = 1'b0;
         repeat (600) begin
            @(posedge clk_sys);
            #1 off = scanLine[4:0] - 5'h1C;
            hit = hit | (off == 5'h00);
            if (off > top) top = off;
         end
         chk("scan_first", hit, 1'b1);
         chk("scan_rows", top, d ? ROWS_DUTY32 : ROWS_DUTY16);
      end
   endtask

   task automatic t_hwreset();
      op(HB, 1'b0, 1'b0, 8'hAF);
      chk("on_both", displayOn, 2'h3);
      wr(REG_RESET, 16'h0001);
      poll();
      op(HL, 1'b1, 1'b0, 8'h00);
      chk("status_hw", rb[7:0], 8'h20);
      chk("off_hw", displayOn, 2'h0);
      rd(4'hF);
      chk("unmapped", rb, 16'h0000);
   endtask

   initial begin
      reset_n = 1'b0;
      regAddr = 4'h0;
      regWrData = 16'h0000;
      regWrite = 1'b0;
      regRead = 1'b0;
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_modes();
      t_lines();
      t_data();
      t_rmw();
      t_scan();
      t_hwreset();
      end_sim();
   end
endmodule // lcd_host_command_port_bench

//--- bench/lhcp_bus_chk.sv
`timescale 1ns/1ns
module lhcp_bus_chk
   import lhcp_pkg::*;
(
   input wire logic             clk_sys,
   input wire logic             reset_n,
   input wire logic             dataCommandSelect,
   input wire logic             readNotWrite,
   input wire logic             leftHalfSelect,
   input wire logic             rightHalfSelect,
   input wire logic             hardwareResetN,
   input wire logic [BUS_W-1:0] hostBusOut,
   input wire logic             hostBusOe,
   input wire logic [BUS_W-1:0] devBusOut,
   input wire logic             devBusOe,
   input wire logic [BUS_W-1:0] busLevel
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------
   // link checks
   // ----------------------------------------
   chk_oe_unselected:
      assert property (devBusOe |-> readNotWrite && (leftHalfSelect || rightHalfSelect))
      else $error("device drives bus while unselected");
   chk_oe_on_read:
      assert property ((leftHalfSelect || rightHalfSelect) && readNotWrite |-> devBusOe)
      else $error("device silent during read");
   chk_status_nibble:
      assert property (leftHalfSelect && $past(leftHalfSelect) && !dataCommandSelect
                       && readNotWrite |-> devBusOut[3:0] == 4'h0)
      else $error("status low bits not zero");
   chk_host_oe_write:
      assert property (hostBusOe |-> !readNotWrite && !devBusOe)
      else $error("host drives bus outside a write");
   chk_sel_width:
      assert property ($rose(leftHalfSelect) |-> leftHalfSelect[*3] ##1 !leftHalfSelect)
      else $error("select pulse width wrong");
   chk_access_gap:
      assert property ($fell(leftHalfSelect || rightHalfSelect)
                       |-> !(leftHalfSelect || rightHalfSelect)[*8])
      else $error("accesses too close");
   chk_reset_pulse:
      assert property ($fell(hardwareResetN) |-> !hardwareResetN[*3] ##[1:3] hardwareResetN)
      else $error("reset pulse length wrong");
   chk_fields_stable:
      assert property (leftHalfSelect && $past(leftHalfSelect)
                       |-> $stable(readNotWrite) && $stable(dataCommandSelect))
      else $error("access kind changed during select");
   cov_status: cover property (leftHalfSelect && readNotWrite && !dataCommandSelect);
   cov_write: cover property (rightHalfSelect && hostBusOe && dataCommandSelect);
   cov_reset: cover property ($fell(hardwareResetN));
endmodule // lhcp_bus_chk

//--- include/lhcp_bus_if.sv
`timescale 1ns/1ns
interface lhcp_bus_if;
   import lhcp_pkg::*;

   logic             dataCommandSelect;
   logic             readNotWrite;
   logic             leftHalfSelect;
   logic             rightHalfSelect;
   logic             hardwareResetN;
   logic [BUS_W-1:0] hostBusOut;
   logic             hostBusOe;
   logic [BUS_W-1:0] devBusOut;
   logic             devBusOe;
   logic [BUS_W-1:0] busLevel;

   // ----------------------------------------------------------------
   // resolved data bus, pulled up when nobody drives
   // ----------------------------------------------------------------
   assign busLevel = devBusOe  ? devBusOut  :
                     hostBusOe ? hostBusOut : BUS_IDLE;

   modport host (
      output dataCommandSelect,
      output readNotWrite,
      output leftHalfSelect,
      output rightHalfSelect,
      output hardwareResetN,
      output hostBusOut,
      output hostBusOe,
      input  busLevel
   );

   modport device (
      input  dataCommandSelect,
      input  readNotWrite,
      input  leftHalfSelect,
      input  rightHalfSelect,
      input  hardwareResetN,
      output devBusOut,
      output devBusOe,
      input  busLevel
   );

endinterface // lhcp_bus_if

//--- include/lhcp_pkg.sv
package lhcp_pkg;

   // ----------------------------------------------------------------
   // bus width and timing
   // ----------------------------------------------------------------
   localparam int unsigned BUS_W           = 8;
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned CYCLE_MIN_NS    = 1000;
   localparam int unsigned STROBE_MIN_NS   = 100;
   localparam int unsigned RESET_LOW_NS    = 160;
   localparam int unsigned CYCLE_CLKS      = (CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STROBE_CLKS     = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GAP_CLKS        = CYCLE_CLKS - STROBE_CLKS;
   localparam int unsigned RESET_LOW_CLKS  = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0]  STROBE_CNT      = 5'(STROBE_CLKS - 1);
   localparam logic [4:0]  GAP_CNT         = 5'(GAP_CLKS - 1);
   localparam logic [4:0]  RESET_LOW_CNT   = 5'(RESET_LOW_CLKS - 1);

   // ----------------------------------------------------------------
   // controller internal timing
   // ----------------------------------------------------------------
   localparam logic [3:0]  BUSY_CLKS       = 4'h2;
   localparam logic [3:0]  RESET_BUSY_CLKS = 4'h8;
   localparam logic [3:0]  SCAN_DIV        = 4'hF;

   // ----------------------------------------------------------------
   // address space and reset values
   // ----------------------------------------------------------------
   localparam logic [6:0]  COL_LIMIT       = 7'h50;
   localparam logic [6:0]  COL_RESET       = 7'h00;
   localparam logic [1:0]  PAGE_RESET      = 2'h3;
   localparam logic [4:0]  LINE_RESET      = 5'h00;
   localparam logic [4:0]  ROWS_DUTY32     = 5'h1F;
   localparam logic [4:0]  ROWS_DUTY16     = 5'h0F;
   localparam int unsigned DRAM_WORDS      = 512;

   // ----------------------------------------------------------------
   // command codes and masks
   // ----------------------------------------------------------------
   localparam logic [7:0]  CMD_DISP_ONOFF  = 8'hAE;
   localparam logic [7:0]  CMD_SEG_DIR     = 8'hA0;
   localparam logic [7:0]  CMD_STATIC      = 8'hA4;
   localparam logic [7:0]  CMD_DUTY        = 8'hA8;
   localparam logic [7:0]  MASK_LOWBIT     = 8'hFE;
   localparam logic [7:0]  CMD_START_LINE  = 8'hC0;
   localparam logic [7:0]  MASK_START_LINE = 8'hE0;
   localparam logic [7:0]  CMD_PAGE        = 8'hB8;
   localparam logic [7:0]  MASK_PAGE       = 8'hFC;
   localparam logic [7:0]  CMD_RMW         = 8'hE0;
   localparam logic [7:0]  CMD_RMW_END     = 8'hEE;
   localparam logic [7:0]  CMD_SW_RESET    = 8'hE2;
   localparam int unsigned CMD_COL_FLAG    = 7;

   // ----------------------------------------------------------------
   // status byte layout
   // ----------------------------------------------------------------
   localparam int unsigned ST_BUSY         = 7;
   localparam int unsigned ST_SEG_DIR      = 6;
   localparam int unsigned ST_DISP_OFF     = 5;
   localparam int unsigned ST_RESETTING    = 4;

   // ----------------------------------------------------------------
   // host register port map
   // ----------------------------------------------------------------
   localparam int unsigned REG_AW          = 4;
   localparam int unsigned REG_DW          = 16;
   localparam logic [3:0]  REG_ACCESS      = 4'h0;
   localparam logic [3:0]  REG_RESET       = 4'h1;
   localparam logic [3:0]  REG_STATUS      = 4'h2;
   localparam logic [3:0]  REG_RDATA       = 4'h3;
   localparam int unsigned ACC_DCSEL       = 8;
   localparam int unsigned ACC_RNW         = 9;
   localparam int unsigned ACC_LEFT        = 10;
   localparam int unsigned ACC_RIGHT       = 11;
   localparam logic [7:0]  BUS_IDLE        = 8'hFF;

   typedef enum logic [1:0] {
      LHCP_IDLE   = 2'b00,
      LHCP_STROBE = 2'b01,
      LHCP_GAP    = 2'b11,
      LHCP_RESET  = 2'b10
   } lhcp_host_state_e;

endpackage

//--- rtl/lhcp_device.sv
// Contract
// - eight-bit two-way data bus for everything
// - select and direction lines decode four access kinds
// - while busy reject all but status read
// - busy flag on top data bit
// - host may skip polling if cycle respected
// - status: busy, segment dir, off, resetting
// - seven-bit presettable column counter
// - each data read or write advances column
// - column stops at its upper limit
// - bit7 clear command loads column; here ignored while read-modify-write is active
// - two-bit page register, set-page only
// - one RAM bit per pixel, byte vertical
// - display on/off by low bit
// - start line command loads five bits
// - start line feeds first row, rows increase
// - segment direction by low bit
// - static drive by low bit
// - duty one-in-32 or one-in-16 by low bit
// - two half selects, one per controller
// - reset pin falling edge resets module; here segment direction, static drive and duty keep their values
// - read-modify-write freezes column, end restores; here only reads hold it, writes still advance it
// - software reset clears line, page three
// - host makes dummy read after column load
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module lhcp_device
   import lhcp_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   lhcp_bus_if.device      bus,
   output      logic [1:0] displayOn,
   output      logic [1:0] segmentDirection,
   output      logic [1:0] staticDrive,
   output      logic [1:0] dutyIs32,
   output      logic [9:0] startLine,
   output      logic [9:0] scanLine
);

   logic       rstPrev_r;
   logic       hwRstEdge;
   logic [3:0] scanDiv_r;
   logic       scanTick;
   logic [1:0] halfSel;
   logic [1:0] oeHalf;
   logic [7:0] outHalf [2];

   // ----------------------------------------------------------------
   // shared: reset pin edge and row scan rate
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rstPrev_r <= 1'b1;
      end else begin
         rstPrev_r <= bus.hardwareResetN;
      end
   end

   assign hwRstEdge = rstPrev_r & ~bus.hardwareResetN;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         scanDiv_r <= 4'h0;
      end else begin
         scanDiv_r <= (scanDiv_r == SCAN_DIV) ? 4'h0 : scanDiv_r + 4'h1;
      end
   end

   assign scanTick = (scanDiv_r == SCAN_DIV);
   assign halfSel  = {bus.rightHalfSelect, bus.leftHalfSelect};

   // ----------------------------------------------------------------
   // one controller per display half
   // ----------------------------------------------------------------
   for (genvar h = 0; h < 2; h++) begin : g_half
      logic [7:0] dram [DRAM_WORDS];
      logic       selPrev_r;
      logic [3:0] busyCnt_r;
      logic       resetting_r;
      logic [6:0] col_r;
      logic [6:0] colSaved_r;
      logic       rmw_r;
      logic [1:0] page_r;
      logic [4:0] line_r;
      logic       dispOn_r;
      logic       segDir_r;
      logic       static_r;
      logic       duty_r;
      logic [7:0] ioLatch_r;
      logic [7:0] out_r;
      logic [4:0] row_r;
      logic [4:0] scan_r;
      logic       take;
      logic       busy;
      logic       cmdWr;
      logic       dataWr;
      logic       dataRd;
      logic       statRd;
      logic       swRst;
      logic       anyRst;
      logic [7:0] cmd;
      logic [8:0] addr;
      logic [7:0] status;

      // access taken on the rising edge of this half's select
      assign take   = halfSel[h] & ~selPrev_r;
      assign busy   = (busyCnt_r != 4'h0);
      assign cmd    = bus.busLevel;
      assign cmdWr  = take & ~busy & ~bus.dataCommandSelect & ~bus.readNotWrite;
      assign dataWr = take & ~busy & bus.dataCommandSelect & ~bus.readNotWrite;
      assign dataRd = take & ~busy & bus.dataCommandSelect & bus.readNotWrite;
      assign statRd = take & ~bus.dataCommandSelect & bus.readNotWrite;
      assign swRst  = cmdWr & (cmd == CMD_SW_RESET);
      assign anyRst = hwRstEdge | swRst;
      assign addr   = {page_r, col_r};

      always_comb begin
         status                = 8'h00;
         status[ST_BUSY]       = busy;
         status[ST_SEG_DIR]    = segDir_r;
         status[ST_DISP_OFF]   = ~dispOn_r;
         status[ST_RESETTING]  = resetting_r;
      end

      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            selPrev_r <= 1'b0;
         end else begin
            selPrev_r <= halfSel[h];
         end
      end

      // internal operation time and reset-in-progress
      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            busyCnt_r   <= 4'h0;
            resetting_r <= 1'b0;
         end else if (anyRst) begin
            busyCnt_r   <= RESET_BUSY_CLKS;
            resetting_r <= 1'b1;
         end else if (cmdWr | dataWr | dataRd) begin
            busyCnt_r <= BUSY_CLKS;
         end else if (busy) begin
            busyCnt_r <= busyCnt_r - 4'h1;
            if (busyCnt_r == 4'h1) begin
               resetting_r <= 1'b0;
            end
         end
      end

      // column counter with read-modify-write save and restore
      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            col_r      <= COL_RESET;
            colSaved_r <= COL_RESET;
            rmw_r      <= 1'b0;
         end else if (hwRstEdge) begin
            col_r <= COL_RESET;
            rmw_r <= 1'b0;
         end else if (cmdWr) begin
            if (!cmd[CMD_COL_FLAG] && !rmw_r) begin
               col_r <= cmd[6:0];
            end else if (cmd == CMD_RMW) begin
               rmw_r      <= 1'b1;
               colSaved_r <= col_r;
            end else if (cmd == CMD_RMW_END && rmw_r) begin
               rmw_r <= 1'b0;
               col_r <= colSaved_r;
            end
         end else if ((dataWr || (dataRd && !rmw_r)) && col_r < COL_LIMIT) begin
            col_r <= col_r + 7'h01;
         end
      end

      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            page_r <= PAGE_RESET;
            line_r <= LINE_RESET;
         end else if (anyRst) begin
            page_r <= PAGE_RESET;
            line_r <= LINE_RESET;
         end else if (cmdWr && (cmd & MASK_PAGE) == CMD_PAGE) begin
            page_r <= cmd[1:0];
         end else if (cmdWr && (cmd & MASK_START_LINE) == CMD_START_LINE) begin
            line_r <= cmd[4:0];
         end
      end

      // mode bits, each chosen by the low bit of its command
      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            dispOn_r <= 1'b0;
            segDir_r <= 1'b0;
            static_r <= 1'b0;
            duty_r   <= 1'b0;
         end else if (hwRstEdge) begin
            dispOn_r <= 1'b0;
         end else if (cmdWr) begin
            if ((cmd & MASK_LOWBIT) == CMD_DISP_ONOFF) begin
               dispOn_r <= cmd[0];
            end
            if ((cmd & MASK_LOWBIT) == CMD_SEG_DIR) begin
               segDir_r <= cmd[0];
            end
            if ((cmd & MASK_LOWBIT) == CMD_STATIC) begin
               static_r <= cmd[0];
            end
            if ((cmd & MASK_LOWBIT) == CMD_DUTY) begin
               duty_r <= cmd[0];
            end
         end
      end

      // display RAM: unaffected by either reset
      always_ff @(posedge clk_sys) begin
         if (dataWr && col_r < COL_LIMIT) begin
            dram[addr] <= cmd;
         end
      end

      // a read returns the old latch and refills it from RAM
      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            ioLatch_r <= 8'h00;
         end else if (dataRd) begin
            ioLatch_r <= (col_r < COL_LIMIT) ? dram[addr] : 8'h00;
         end
      end

      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            out_r <= 8'h00;
         end else if (statRd) begin
            out_r <= status;
         end else if (dataRd) begin
            out_r <= ioLatch_r;
         end
      end

      // row scan: first row shows the start line, rows count up
      always_ff @(posedge clk_sys or negedge reset_n) begin
         if (!reset_n) begin
            row_r  <= 5'h00;
            scan_r <= LINE_RESET;
         end else if (scanTick) begin
            row_r  <= (row_r >= (duty_r ? ROWS_DUTY32 : ROWS_DUTY16)) ? 5'h00 : row_r + 5'h01;
            scan_r <= line_r + row_r;
         end
      end

      assign oeHalf[h]           = halfSel[h] & bus.readNotWrite;
      assign outHalf[h]          = out_r;
      assign displayOn[h]        = dispOn_r;
      assign segmentDirection[h] = segDir_r;
      assign staticDrive[h]      = static_r;
      assign dutyIs32[h]         = duty_r;
      assign startLine[5*h +: 5] = line_r;
      assign scanLine[5*h +: 5]  = scan_r;
   end

   assign bus.devBusOe  = |oeHalf;
   assign bus.devBusOut = oeHalf[0] ? outHalf[0] : outHalf[1];

endmodule // lhcp_device

//--- rtl/lhcp_host.sv
`timescale 1ns/1ns
module lhcp_host
   import lhcp_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   input  wire logic [REG_AW-1:0] regAddr,
   input  wire logic [REG_DW-1:0] regWrData,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output      logic [REG_DW-1:0] regRdData,
   lhcp_bus_if.host               bus
);

   lhcp_host_state_e state_r;
   logic [4:0]       cnt_r;
   logic [7:0]       wrByte_r;
   logic             dcSel_r;
   logic             rnw_r;
   logic [1:0]       halfSel_r;
   logic [7:0]       rdByte_r;
   logic [REG_DW-1:0] regRdData_r;
   logic             idle;
   logic             startAcc;
   logic             startRst;

   assign idle     = (state_r == LHCP_IDLE);
   assign startAcc = idle & regWrite & (regAddr == REG_ACCESS);
   assign startRst = idle & regWrite & (regAddr == REG_RESET);

   // ----------------------------------------------------------------
   // sequencer: strobe, then hold out the least cycle time
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= LHCP_IDLE;
         cnt_r   <= 5'h00;
      end else begin
         unique case (state_r)
            LHCP_IDLE: begin
               if (startAcc) begin
                  state_r <= LHCP_STROBE;
                  cnt_r   <= STROBE_CNT;
               end else if (startRst) begin
                  state_r <= LHCP_RESET;
                  cnt_r   <= RESET_LOW_CNT;
               end
            end
            LHCP_STROBE: begin
               if (cnt_r == 5'h00) begin
                  state_r <= LHCP_GAP;
                  cnt_r   <= GAP_CNT;
               end else begin
                  cnt_r <= cnt_r - 5'h01;
               end
            end
            LHCP_GAP, LHCP_RESET: begin
               if (cnt_r == 5'h00) begin
                  state_r <= (state_r == LHCP_RESET) ? LHCP_GAP : LHCP_IDLE;
                  cnt_r   <= GAP_CNT;
               end else begin
                  cnt_r <= cnt_r - 5'h01;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // access fields held for the whole strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wrByte_r  <= 8'h00;
         dcSel_r   <= 1'b0;
         rnw_r     <= 1'b1;
         halfSel_r <= 2'h0;
      end else if (startAcc) begin
         wrByte_r  <= regWrData[7:0];
         dcSel_r   <= regWrData[ACC_DCSEL];
         rnw_r     <= regWrData[ACC_RNW];
         halfSel_r <= {regWrData[ACC_RIGHT], regWrData[ACC_LEFT]};
      end
   end

   // capture read byte on the last strobe cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdByte_r <= 8'h00;
      end else if (state_r == LHCP_STROBE && cnt_r == 5'h00 && rnw_r) begin
         rdByte_r <= bus.busLevel;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         regRdData_r <= '0;
      end else if (regRead) begin
         unique case (regAddr)
            REG_STATUS: regRdData_r <= {15'h0000, ~idle};
            REG_RDATA:  regRdData_r <= {8'h00, rdByte_r};
            default:    regRdData_r <= '0;
         endcase
      end
   end

   assign regRdData              = regRdData_r;
   assign bus.dataCommandSelect  = dcSel_r;
   assign bus.readNotWrite       = rnw_r;
   assign bus.leftHalfSelect     = (state_r == LHCP_STROBE) & halfSel_r[0];
   assign bus.rightHalfSelect    = (state_r == LHCP_STROBE) & halfSel_r[1];
   assign bus.hardwareResetN     = (state_r != LHCP_RESET);
   assign bus.hostBusOut         = wrByte_r;
   assign bus.hostBusOe          = (state_r == LHCP_STROBE) & ~rnw_r;

endmodule // lhcp_host
